// *** common/pmis_pkg.sv ***
// Shared constants and types for the PHY/MAC start-up sequencer.
// Assumes a single 10 MHz bus clock and a MAC reached over AXI4-Lite.
package pmis_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_NS     = 100000;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W      = 16;

  // ************************************************************
  // Own register map (AHB-Lite byte addresses)
  // ************************************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RDATA  = 8'h08;
  localparam logic [7:0] REG_POLLS  = 8'h0c;
  localparam int CTRL_LB_POS   = 0;
  localparam int ST_CFG_POS    = 4;
  localparam int ST_GEN_POS    = 5;
  localparam int ST_LOCK_POS   = 6;
  localparam int ST_MODE_POS   = 7;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ************************************************************
  // MAC register addresses and values
  // ************************************************************
  localparam logic [31:0] MAC_RX_CFG     = 32'h0000_0404;
  localparam logic [31:0] MAC_TX_CFG     = 32'h0000_0408;
  localparam logic [31:0] MAC_MDIO_CFG   = 32'h0000_0500;
  localparam logic [31:0] MAC_MDIO_CMD   = 32'h0000_0504;
  localparam logic [31:0] MAC_MDIO_WDATA = 32'h0000_0508;
  localparam logic [31:0] MAC_MDIO_RDATA = 32'h0000_050c;
  localparam logic [31:0] RX_CFG_VAL     = 32'h1000_0000;
  localparam logic [31:0] TX_CFG_VAL     = 32'h1000_0000;
  // MDIO enable plus divider for 125 MHz management clock
  localparam logic [31:0] MDIO_CFG_VAL   = 32'h0000_0058;
  localparam logic [31:0] MDIO_INIT      = 32'h0000_0800;
  localparam logic [31:0] MDIO_PORT_DEV  = 32'h0003_0000;
  localparam int          MDIO_READY_POS = 7;
  localparam logic [1:0]  MDIO_OP_ADDR   = 2'h0;
  localparam logic [1:0]  MDIO_OP_WRITE  = 2'h1;
  localparam logic [1:0]  MDIO_OP_READ   = 2'h3;

  // ************************************************************
  // PHY (PCS) registers
  // ************************************************************
  localparam logic [15:0] PCS_CTRL_REG   = 16'h0000;
  localparam logic [15:0] PCS_STAT_REG   = 16'h0020;
  localparam logic [15:0] PCS_CTRL_LB    = 16'h6040;
  localparam logic [15:0] PCS_CTRL_NORM  = 16'h2040;
  localparam int          PCS_LB_POS     = 14;
  localparam int          PCS_LOCK_POS   = 0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    PH_IDLE     = 4'h0,
    PH_SETTLE   = 4'h1,
    PH_MDIO_CFG = 4'h2,
    PH_RX_CFG   = 4'h3,
    PH_TX_CFG   = 4'h4,
    PH_PHY_CTRL = 4'h5,
    PH_VERIFY   = 4'h6,
    PH_LOCK     = 4'h7,
    PH_RUN      = 4'h8
  } pmis_phase_t;

  typedef enum logic [1:0] {
    MS_TXD  = 2'h0,
    MS_CMD  = 2'h1,
    MS_POLL = 2'h2,
    MS_RXD  = 2'h3
  } pmis_mstep_t;

endpackage

// *** src/pmis_axil_master.sv ***
// Single-access AXI4-Lite master used by the sequencer.
// Assumes one request at a time; req is only raised while busy is low.
module pmis_axil_master (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        req,
  input  wire logic        req_we,
  input  wire logic [31:0] req_addr,
  input  wire logic [31:0] req_wdata,
  output logic             done,
  output logic             resp_err,
  output logic [31:0]      rdata,
  output logic             awvalid,
  output logic [31:0]      awaddr,
  input  wire logic        awready,
  output logic             wvalid,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  input  wire logic        wready,
  input  wire logic        bvalid,
  input  wire logic [1:0]  bresp,
  output logic             bready,
  output logic             arvalid,
  output logic [31:0]      araddr,
  input  wire logic        arready,
  input  wire logic        rvalid,
  input  wire logic [31:0] rdata_in,
  input  wire logic [1:0]  rresp,
  output logic             rready
);
  import pmis_pkg::*;

  typedef struct packed {
    logic        busy;
    logic        awvalid;
    logic        wvalid;
    logic        bready;
    logic        arvalid;
    logic        rready;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        done;
    logic        err;
  } pmis_axm_t;

  pmis_axm_t s;
  pmis_axm_t next_s;

  // ************************************************************
  // Transaction engine
  // ************************************************************
  // Start, channel handshakes and completion
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    if (!s.busy && req) begin
      next_s.busy = 1'b1;
      next_s.addr = req_addr;
      next_s.err  = 1'b0;
      if (req_we) begin
        next_s.awvalid = 1'b1;
        next_s.wvalid  = 1'b1;
        next_s.bready  = 1'b1;
        next_s.wdata   = req_wdata;
      end else begin
        next_s.arvalid = 1'b1;
        next_s.rready  = 1'b1;
      end
    end
    if (s.awvalid && awready) begin
      next_s.awvalid = 1'b0;
    end
    if (s.wvalid && wready) begin
      next_s.wvalid = 1'b0;
    end
    if (s.arvalid && arready) begin
      next_s.arvalid = 1'b0;
    end
    // Response ends the access; one outstanding only
    if (s.bready && bvalid) begin
      next_s.bready = 1'b0;
      next_s.busy   = 1'b0;
      next_s.done   = 1'b1;
      next_s.err    = (bresp != 2'h0);
    end
    if (s.rready && rvalid) begin
      next_s.rready = 1'b0;
      next_s.busy   = 1'b0;
      next_s.done   = 1'b1;
      next_s.rdata  = rdata_in;
      next_s.err    = (rresp != 2'h0);
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done     = s.done;
  assign resp_err = s.err;
  assign rdata    = s.rdata;
  assign awvalid  = s.awvalid;
  assign awaddr   = s.addr;
  assign wvalid   = s.wvalid;
  assign wdata    = s.wdata;
  assign wstrb    = 4'hf;
  assign bready   = s.bready;
  assign arvalid  = s.arvalid;
  assign araddr   = s.addr;
  assign rready   = s.rready;

endmodule

// *** src/pmis_sequencer.sv ***
// PHY and MAC start-up sequencer with AHB-Lite control registers.
// Assumes the MAC register slave answers every AXI4-Lite access in time,
// and that rx_frame_ok pulses once per frame received without error.

module pmis_sequencer #(
  parameter bit MGMT_PRESENT  = 1'b1,
  parameter int SETTLE_CYCLES = pmis_pkg::SETTLE_CYC,
  parameter int ACT_DIV       = 1,
  parameter int ACT_W         = 8
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic             m_axi_awvalid,
  output logic [31:0]      m_axi_awaddr,
  input  wire logic        m_axi_awready,
  output logic             m_axi_wvalid,
  output logic [31:0]      m_axi_wdata,
  output logic [3:0]       m_axi_wstrb,
  input  wire logic        m_axi_wready,
  input  wire logic        m_axi_bvalid,
  input  wire logic [1:0]  m_axi_bresp,
  output logic             m_axi_bready,
  output logic             m_axi_arvalid,
  output logic [31:0]      m_axi_araddr,
  input  wire logic        m_axi_arready,
  input  wire logic        m_axi_rvalid,
  input  wire logic [31:0] m_axi_rdata,
  input  wire logic [1:0]  m_axi_rresp,
  output logic             m_axi_rready,
  input  wire logic        rx_frame_ok,
  output logic             pat_gen_enable,
  output logic             phy_configured,
  output logic             rx_activity
);
  import pmis_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    pmis_phase_t          phase;
    pmis_mstep_t          mstep;
    logic [SETTLE_W-1:0]  settle_cnt;
    logic                 req;
    logic                 req_we;
    logic [31:0]          req_addr;
    logic [31:0]          req_wdata;
    logic                 pending;
    logic                 addr_done;
    logic                 loopback;
    logic                 lb_prev;
    logic                 mode_lb;
    logic                 configured;
    logic                 gen_en;
    logic                 lock_seen;
    logic                 mode_ok;
    logic [15:0]          last_rdata;
    logic [15:0]          poll_cnt;
    logic [ACT_W-1:0]     act_cnt;
    logic                 activity;
    logic                 hreadyout;
    logic [31:0]          hrdata;
    logic                 wr_pend;
    logic [7:0]           wr_addr;
  } pmis_seq_t;

  pmis_seq_t s;
  pmis_seq_t next_s;

  // Engine results and per-phase access descriptor
  logic        acc_done;
  logic [31:0] acc_rdata;
  logic        acc_mdio;
  logic        acc_read;
  logic [31:0] acc_mac_addr;
  logic [31:0] acc_data;
  logic [15:0] acc_reg;
  logic        fin;
  logic [15:0] result;
  logic        ahb_addr_phase;

  // ************************************************************
  // AXI4-Lite access engine
  // ************************************************************
  pmis_axil_master u_axm (
    .hclk(hclk), .hresetn(hresetn), .req(s.req), .req_we(s.req_we),
    .req_addr(s.req_addr), .req_wdata(s.req_wdata), .done(acc_done), .resp_err(),
    .rdata(acc_rdata), .awvalid(m_axi_awvalid), .awaddr(m_axi_awaddr),
    .awready(m_axi_awready), .wvalid(m_axi_wvalid), .wdata(m_axi_wdata),
    .wstrb(m_axi_wstrb), .wready(m_axi_wready), .bvalid(m_axi_bvalid),
    .bresp(m_axi_bresp), .bready(m_axi_bready), .arvalid(m_axi_arvalid),
    .araddr(m_axi_araddr), .arready(m_axi_arready), .rvalid(m_axi_rvalid),
    .rdata_in(m_axi_rdata), .rresp(m_axi_rresp), .rready(m_axi_rready)
  );

  // ************************************************************
  // Access descriptor per phase
  // ************************************************************
  // Selects target register and data for the current phase
  always_comb begin
    acc_mdio     = 1'b0;
    acc_read     = 1'b0;
    // MDIO enable and clock unless overridden
    acc_mac_addr = MAC_MDIO_CFG;
    acc_data     = MDIO_CFG_VAL;
    acc_reg      = PCS_CTRL_REG;
    case (s.phase)
      PH_RX_CFG: begin
        acc_mac_addr = MAC_RX_CFG;
        acc_data     = RX_CFG_VAL;
      end
      PH_TX_CFG: begin
        acc_mac_addr = MAC_TX_CFG;
        acc_data     = TX_CFG_VAL;
      end
      PH_PHY_CTRL: begin
        acc_mdio = 1'b1;
        acc_data = {16'h0, (s.mode_lb ? PCS_CTRL_LB : PCS_CTRL_NORM)};
      end
      PH_VERIFY: begin
        acc_mdio = 1'b1;
        acc_read = 1'b1;
      end
      PH_LOCK: begin
        acc_mdio = 1'b1;
        acc_read = 1'b1;
        acc_reg  = PCS_STAT_REG;
      end
      default: acc_mdio = 1'b0;
    endcase
  end

  assign ahb_addr_phase = hsel && hready && htrans[1];

  // ************************************************************
  // Next-state logic
  // ************************************************************
  // Sequencer, MDIO sub-steps, registers and activity monitor
  always_comb begin
    next_s         = s;
    next_s.req     = 1'b0;
    next_s.lb_prev = s.loopback;
    fin            = 1'b0;
    result         = acc_rdata[15:0];

    // Access issue and completion for phases that talk to the MAC
    if (s.phase inside {PH_MDIO_CFG, PH_RX_CFG, PH_TX_CFG, PH_PHY_CTRL,
                        PH_VERIFY, PH_LOCK}) begin
      if (!s.pending) begin
        // issue only when nothing is outstanding
        next_s.req     = 1'b1;
        next_s.pending = 1'b1;
        next_s.req_we  = !(acc_mdio && (s.mstep inside {MS_POLL, MS_RXD}));
        if (!acc_mdio) begin
          next_s.req_addr  = acc_mac_addr;
          next_s.req_wdata = acc_data;
        end else begin
          // MDIO frames through the MAC command registers
          case (s.mstep)
            MS_TXD: begin
              next_s.req_addr  = MAC_MDIO_WDATA;
              next_s.req_wdata = s.addr_done ? acc_data : {16'h0, acc_reg};
            end
            MS_CMD: begin
              next_s.req_addr  = MAC_MDIO_CMD;
              next_s.req_wdata = MDIO_INIT | MDIO_PORT_DEV |
                {16'h0, (!s.addr_done ? MDIO_OP_ADDR :
                         (acc_read ? MDIO_OP_READ : MDIO_OP_WRITE)), 14'h0};
            end
            MS_POLL: next_s.req_addr = MAC_MDIO_CMD;
            default: next_s.req_addr = MAC_MDIO_RDATA;
          endcase
        end
      end else if (acc_done) begin
        // next access waits for this handshake
        next_s.pending = 1'b0;
        if (!acc_mdio) begin
          fin = 1'b1;
        end else begin
          case (s.mstep)
            MS_TXD: next_s.mstep = MS_CMD;
            MS_CMD: next_s.mstep = MS_POLL;
            MS_POLL: begin
              // poll until the MDIO frame completes
              if (acc_rdata[MDIO_READY_POS]) begin
                if (!s.addr_done) begin
                  next_s.addr_done = 1'b1;
                  next_s.mstep     = MS_TXD;
                end else if (acc_read) begin
                  next_s.mstep = MS_RXD;
                end else begin
                  fin = 1'b1;
                end
              end
            end
            default: fin = 1'b1;
          endcase
        end
        if (fin) begin
          next_s.addr_done = 1'b0;
          next_s.mstep     = MS_TXD;
          if (acc_read) next_s.last_rdata = result;
        end
      end
    end

    // Phase sequencing
    case (s.phase)
      // no accesses without the management interface
      PH_IDLE: if (MGMT_PRESENT) next_s.phase = PH_SETTLE;
      PH_SETTLE: begin
        next_s.settle_cnt = s.settle_cnt + 1'b1;
        if (s.settle_cnt == SETTLE_W'(SETTLE_CYCLES - 1)) begin
          next_s.settle_cnt = '0;
          next_s.phase      = PH_MDIO_CFG;
        end
      end
      PH_MDIO_CFG: if (fin) next_s.phase = PH_RX_CFG;
      PH_RX_CFG: if (fin) next_s.phase = PH_TX_CFG;
      PH_TX_CFG: if (fin) begin
        next_s.mode_lb = s.loopback;
        next_s.phase   = PH_PHY_CTRL;
      end
      PH_PHY_CTRL: if (fin) next_s.phase = PH_VERIFY;
      PH_VERIFY: if (fin) begin
        // confirm programmed mode, rewrite on mismatch
        next_s.mode_ok = (result[PCS_LB_POS] == s.mode_lb);
        if (result[PCS_LB_POS] != s.mode_lb) begin
          next_s.phase = PH_PHY_CTRL;
        end else if (s.mode_lb) begin
          next_s.configured = 1'b1;
          next_s.gen_en     = 1'b1;
          next_s.phase      = PH_RUN;
        end else begin
          next_s.phase = PH_LOCK;
        end
      end
      PH_LOCK: if (fin) begin
        if (result[PCS_LOCK_POS]) begin
          next_s.lock_seen  = 1'b1;
          next_s.configured = 1'b1;
          next_s.gen_en     = 1'b1;
          next_s.phase      = PH_RUN;
        end else begin
          next_s.poll_cnt = s.poll_cnt + 1'b1;
        end
      end
      PH_RUN: if (s.loopback && !s.lb_prev) begin
        next_s.configured = 1'b0;
        next_s.gen_en     = 1'b0;
        next_s.lock_seen  = 1'b0;
        next_s.mode_ok    = 1'b0;
        next_s.poll_cnt   = '0;
        next_s.phase      = PH_SETTLE;
      end
      default: begin
        next_s.phase = PH_IDLE;
      end
    endcase

    if (rx_frame_ok) begin
      if (s.act_cnt == ACT_W'(ACT_DIV - 1)) begin
        next_s.act_cnt  = '0;
        next_s.activity = !s.activity;
      end else begin
        next_s.act_cnt = s.act_cnt + 1'b1;
      end
    end

    // AHB-Lite slave: write data phase lands in control register
    next_s.wr_pend = 1'b0;
    if (s.wr_pend && s.wr_addr == REG_CTRL) next_s.loopback = hwdata[CTRL_LB_POS];
    // Address phase: latch write, prepare read data
    if (ahb_addr_phase) begin
      next_s.hrdata = '0;
      if (hwrite) begin
        next_s.wr_pend = 1'b1;
        next_s.wr_addr = haddr[7:0];
      end else if (haddr[7:0] == REG_CTRL) begin
        next_s.hrdata[CTRL_LB_POS] = s.loopback;
      end else if (haddr[7:0] == REG_STATUS) begin
        next_s.hrdata[3:0]          = s.phase;
        next_s.hrdata[ST_CFG_POS]   = s.configured;
        next_s.hrdata[ST_GEN_POS]   = s.gen_en;
        next_s.hrdata[ST_LOCK_POS]  = s.lock_seen;
        next_s.hrdata[ST_MODE_POS]  = s.mode_ok;
      end else if (haddr[7:0] == REG_RDATA) begin
        next_s.hrdata[15:0] = s.last_rdata;
      end else if (haddr[7:0] == REG_POLLS) begin
        next_s.hrdata[15:0] = s.poll_cnt;
      end
    end
    next_s.hreadyout = 1'b1;
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Everything restarts from reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s           <= '0;
      s.hreadyout <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops, except hresp tied low and m_axi_wstrb tied to 4'hf
  assign hreadyout      = s.hreadyout;
  assign hrdata         = s.hrdata;
  assign hresp          = 1'b0;
  assign pat_gen_enable = s.gen_en;
  assign phy_configured = s.configured;
  assign rx_activity    = s.activity;

endmodule

// *** dv/pmis_mac_model.sv ***
// MAC register slave model: AXI4-Lite slave, MDIO engine, PHY registers.
// Assumes the master raises aw and w together, one access at a time.
module pmis_mac_model
  import pmis_pkg::*;
#(parameter int LOCK_AFTER = 3) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        awvalid,
  input  wire logic [31:0] awaddr,
  output logic             awready,
  input  wire logic        wvalid,
  input  wire logic [31:0] wdata,
  output logic             wready,
  output logic             bvalid,
  output logic [1:0]       bresp,
  input  wire logic        bready,
  input  wire logic        arvalid,
  input  wire logic [31:0] araddr,
  output logic             arready,
  output logic             rvalid,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        rready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] wd, rdv, stat_reads, nwr;
  logic [31:0] log_a [3];
  logic [31:0] log_d [3];
  logic [15:0] phy_a, phy_ctrl;
  logic [1:0]  busy;
  logic [3:0]  cyc;
  // one response outstanding; slow grants every other pair of cycles
  assign awready = awvalid & wvalid & cyc[1] & !bvalid;
  assign wready  = awready;
  assign arready = arvalid & cyc[1] & !rvalid;
  assign bresp   = 2'h0;
  assign rresp   = 2'h0;
  // MDIO command engine, ready after two busy polls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {bvalid, rvalid, busy, cyc, phy_a, phy_ctrl} <= '0;
      {rdata, wd, rdv, stat_reads, nwr} <= '0;
    end else begin
      cyc <= cyc + 4'h1;
      if (bvalid && bready) bvalid <= 1'b0;
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        rdata  <= ~rdata;
      end
      if (awready) begin
        bvalid <= 1'b1;
        nwr    <= nwr + 32'h1;
        if (nwr < 32'h3) begin
          log_a[nwr[1:0]] <= awaddr;
          log_d[nwr[1:0]] <= wdata;
        end
        if (awaddr == MAC_MDIO_WDATA) wd <= wdata;
        if (awaddr == MAC_MDIO_CMD) begin
          busy <= 2'h2;
          case (wdata[15:14])
            MDIO_OP_ADDR: phy_a <= wd[15:0];
            MDIO_OP_WRITE: if (phy_a == PCS_CTRL_REG) phy_ctrl <= wd[15:0];
            default: begin
              rdv <= (phy_a == PCS_STAT_REG) ? {31'h0, stat_reads >= LOCK_AFTER}
                                             : {16'h0, phy_ctrl};
              if (phy_a == PCS_STAT_REG) stat_reads <= stat_reads + 32'h1;
            end
          endcase
        end
      end
      if (arready) begin
        rvalid <= 1'b1;
        if (araddr == MAC_MDIO_CMD) begin
          rdata <= {24'h0, busy == 2'h0, 7'h0};
          if (busy != 2'h0) busy <= busy - 2'h1;
        end else begin
          rdata <= (araddr == MAC_MDIO_RDATA) ? rdv : 32'h0;
        end
      end
    end
  end
endmodule

// *** dv/pmis_sequencer_checker.sv ***
// Assertions on the sequencer's AXI4-Lite master and status outputs.
// Assumes it is bound to every sequencer instance.
module pmis_sequencer_checker
  import pmis_pkg::*;
#(parameter int SETTLE_CYCLES = SETTLE_CYC) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        m_axi_awvalid,
  input wire logic [31:0] m_axi_awaddr,
  input wire logic        m_axi_awready,
  input wire logic [31:0] m_axi_wdata,
  input wire logic        m_axi_bready,
  input wire logic        m_axi_arvalid,
  input wire logic [31:0] m_axi_araddr,
  input wire logic        m_axi_arready,
  input wire logic        m_axi_rready,
  input wire logic        rx_frame_ok,
  input wire logic        pat_gen_enable,
  input wire logic        phy_configured,
  input wire logic        rx_activity
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] since;
  // Cycles since reset release, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) since <= '0;
    else if (since != 16'hffff) since <= since + 16'h1;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_aw_wait; m_axi_awvalid && !m_axi_awready; endsequence
  sequence s_ar_wait; m_axi_arvalid && !m_axi_arready; endsequence
  property p_settle; m_axi_awvalid |-> int'(since) >= SETTLE_CYCLES; endproperty
  property p_mdio; m_axi_awvalid && m_axi_awaddr == MAC_MDIO_CFG |-> m_axi_wdata == MDIO_CFG_VAL;
  endproperty
  property p_rx; m_axi_awvalid && m_axi_awaddr == MAC_RX_CFG |-> m_axi_wdata == RX_CFG_VAL;
  endproperty
  property p_tx; m_axi_awvalid && m_axi_awaddr == MAC_TX_CFG |-> m_axi_wdata == TX_CFG_VAL;
  endproperty
  property p_one; !((m_axi_awvalid || m_axi_bready) && (m_axi_arvalid || m_axi_rready));
  endproperty
  property p_aw_hold; s_aw_wait |=> m_axi_awvalid && $stable(m_axi_awaddr); endproperty
  property p_ar_hold; s_ar_wait |=> m_axi_arvalid && $stable(m_axi_araddr); endproperty
  property p_gen; pat_gen_enable |-> phy_configured; endproperty
  property p_act; $changed(rx_activity) |-> $past(rx_frame_ok) || $past(rx_frame_ok, 2);
  endproperty
  a_settle: assert property (p_settle) else $error("AXI write before settle");
  a_mdio: assert property (p_mdio) else $error("MDIO setup value wrong");
  a_rx: assert property (p_rx) else $error("receiver config value wrong");
  a_tx: assert property (p_tx) else $error("transmitter config value wrong");
  a_one: assert property (p_one) else $error("two accesses outstanding");
  a_aw_hold: assert property (p_aw_hold) else $error("write address dropped");
  a_ar_hold: assert property (p_ar_hold) else $error("read address dropped");
  a_gen: assert property (p_gen) else $error("generator on before configured");
  a_act: assert property (p_act) else $error("activity toggled without frame");
endmodule
bind pmis_sequencer pmis_sequencer_checker #(.SETTLE_CYCLES(SETTLE_CYCLES))
  pmis_sequencer_checker_i (.hclk(hclk), .hresetn(hresetn), .m_axi_awvalid(m_axi_awvalid),
  .m_axi_awaddr(m_axi_awaddr), .m_axi_awready(m_axi_awready), .m_axi_wdata(m_axi_wdata),
  .m_axi_bready(m_axi_bready), .m_axi_arvalid(m_axi_arvalid), .m_axi_araddr(m_axi_araddr),
  .m_axi_arready(m_axi_arready), .m_axi_rready(m_axi_rready), .rx_frame_ok(rx_frame_ok),
  .pat_gen_enable(pat_gen_enable), .phy_configured(phy_configured),
  .rx_activity(rx_activity));

// *** dv/tb_pmis_sequencer.sv ***
// Self-checking bench: AHB-Lite register tasks drive the sequencer.
// Assumes the MAC model answers every AXI4-Lite access.
module tb_pmis_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  import pmis_pkg::*;
  localparam logic [31:0] EA [3] = '{MAC_MDIO_CFG, MAC_RX_CFG, MAC_TX_CFG};
  localparam logic [31:0] ED [3] = '{MDIO_CFG_VAL, RX_CFG_VAL, TX_CFG_VAL};
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_frame_ok;
  logic [31:0] haddr, hwdata, hrdata, awaddr, wdata, araddr, rdata, q;
  logic [1:0]  htrans, bresp, rresp;
  logic [2:0]  hsize;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, pat_gen_enable, phy_configured, rx_activity;
  int          fails, checks;
  int          cyc = 0;
  pmis_sequencer #(.SETTLE_CYCLES(10)) pmis_sequencer_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .m_axi_awvalid(awvalid), .m_axi_awaddr(awaddr), .m_axi_awready(awready),
    .m_axi_wvalid(wvalid), .m_axi_wdata(wdata), .m_axi_wstrb(wstrb), .m_axi_wready(wready),
    .m_axi_bvalid(bvalid), .m_axi_bresp(bresp), .m_axi_bready(bready),
    .m_axi_arvalid(arvalid), .m_axi_araddr(araddr), .m_axi_arready(arready),
    .m_axi_rvalid(rvalid), .m_axi_rdata(rdata), .m_axi_rresp(rresp), .m_axi_rready(rready),
    .rx_frame_ok(rx_frame_ok), .pat_gen_enable(pat_gen_enable),
    .phy_configured(phy_configured), .rx_activity(rx_activity));
  pmis_mac_model pmis_mac_model_i (
    .hclk(hclk), .hresetn(hresetn), .awvalid(awvalid), .awaddr(awaddr), .awready(awready),
    .wvalid(wvalid), .wdata(wdata), .wready(wready), .bvalid(bvalid), .bresp(bresp),
    .bready(bready), .arvalid(arvalid), .araddr(araddr), .arready(arready),
    .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .rready(rready));
  // ****
  // Clock, timeout and tasks
  // ****
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      finish_test();
    end
  end
  task automatic finish_test();
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks = checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Single AHB-Lite transfer; read data lands in q
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wait_cfg(input logic v);
    int n;
    n = 0;
    while (phy_configured !== v && n < 5000) begin
      @(posedge hclk);
      n = n + 1;
    end
    chk("phy_configured", {31'h0, v}, {31'h0, phy_configured});
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    {hresetn, hsel, hwrite, rx_frame_ok, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    fails = 0;
    checks = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, REG_STATUS, '0);
    chk("status_early", 32'h0, q & 32'h70);
    ahb(1'b0, 8'h10, '0);
    chk("unmapped", 32'h0, q);
    chk("hresp_wstrb", 32'hf, {27'h0, hresp, wstrb});
    wait_cfg(1'b1);
    for (int i = 0; i < 3; i++) begin
      chk("mac_wr_addr", EA[i], pmis_mac_model_i.log_a[i]);
      chk("mac_wr_data", ED[i], pmis_mac_model_i.log_d[i]);
    end
    chk("phy_ctrl", {16'h0, PCS_CTRL_NORM}, {16'h0, pmis_mac_model_i.phy_ctrl});
    chk("lock_reads", 32'h4, pmis_mac_model_i.stat_reads);
    ahb(1'b0, REG_POLLS, '0);
    chk("lock_polls", 32'h3, q);
    ahb(1'b0, REG_RDATA, '0);
    chk("last_mdio_read", 32'h1, q);
    ahb(1'b0, REG_STATUS, '0);
    chk("status_run", 32'hf0, q & 32'hf0);
    for (int i = 1; i <= 3; i++) begin
      rx_frame_ok <= 1'b1;
      @(posedge hclk);
      rx_frame_ok <= 1'b0;
      repeat (3) @(posedge hclk);
      chk("rx_activity", 32'(i % 2), {31'h0, rx_activity});
    end
    ahb(1'b1, REG_CTRL, 32'h1);
    wait_cfg(1'b0);
    chk("gen_off", 32'h0, {31'h0, pat_gen_enable});
    wait_cfg(1'b1);
    chk("phy_ctrl_lb", {16'h0, PCS_CTRL_LB}, {16'h0, pmis_mac_model_i.phy_ctrl});
    chk("no_lock_poll", 32'h4, pmis_mac_model_i.stat_reads);
    ahb(1'b0, REG_STATUS, '0);
    chk("status_lb", 32'hb0, q & 32'hf0);
    ahb(1'b1, REG_CTRL, 32'h0);
    repeat (20) @(posedge hclk);
    chk("stay_run", 32'h1, {31'h0, pat_gen_enable});
    finish_test();
  end
endmodule
